// >>> logic/sfe_defines.svh
// constants for the stack frame enter/leave sequencer
// assumes a 32-bit flat stack addressed in bytes
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define SFE_ADDR_W 32
`define SFE_STOR_W 16
`define SFE_LVL_IN_W 8
`define SFE_LVL_MSB 4
`define SFE_CNT_W 5

// ----------------------------------------------------------------
// stack step, reset values and depth limit
// ----------------------------------------------------------------
`define SFE_WORD_BYTES 32'h0000_0004
`define SFE_SP_RESET 32'h0000_0000
`define SFE_BP_RESET 32'h0000_0000
`define SFE_MAX_LEVEL 31

`endif

// >>> logic/sfe_frame_seq.sv
// frame creation and release sequencer for procedure entry and exit
// assumes decoder, register writes and stack memory all run on core_clk
//
// Notes on behaviour
// R1: creation takes byte count and depth 0..31
// R2: depth zero: push base, copy, subtract count
// R3: depth-1 copies, base lowered by four each
// R4: nonzero depth pushes latched frame value last
// R5: finally base gets latched value, stack lowered
// R6: base ends addressing highest display doubleword
// R7: display entries are doublewords, first old base
// R8: depth one leaves old and new base
// R9: base-relative data accesses default to stack segment
// R10: depth never touches privilege levels
// R11: release copies base into stack pointer first
// R12: release then pops saved base, restoring stack
// R13: push predecrements by four, pop postincrements
// R14: only low five depth bits are used
`timescale 1ns/1ps
`include "sfe_defines.svh"

module sfe_frame_seq #(
    parameter int MAX_LEVEL = `SFE_MAX_LEVEL
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // command from the decoder
    input wire logic cmd_valid,
    input sfe_pkg::sfe_cmd_type cmd,
    output logic cmd_ready,
    output logic cmd_done,
    // register file write port, taken only while idle
    input wire logic reg_wr_en,
    input wire logic reg_wr_sel_bp,
    input wire logic [`SFE_ADDR_W-1:0] reg_wr_data,
    // pointer values seen by the rest of the core
    output logic [`SFE_ADDR_W-1:0] frame_base_pointer,
    output logic [`SFE_ADDR_W-1:0] stack_pointer_reg,
    // segment default for the address generator
    input wire logic agu_base_is_bp,
    output logic agu_use_stack_seg,
    // stack memory
    output logic mem_req,
    output sfe_pkg::sfe_mem_type mem_op,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (MAX_LEVEL < 0 || MAX_LEVEL > `SFE_MAX_LEVEL) begin : g_bad_level
        $error("MAX_LEVEL must lie in 0..31");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_BP,
        ST_COPY_RD,
        ST_COPY_WR,
        ST_PUSH_FRAME,
        ST_FINISH,
        ST_POP_BP
    } sfe_fsm_type;

    typedef struct packed {
        sfe_fsm_type fsm;
        logic issued;
        logic ready;
        logic done;
        logic stack_seg;
        logic [`SFE_ADDR_W-1:0] bp;
        logic [`SFE_ADDR_W-1:0] sp;
        logic [`SFE_ADDR_W-1:0] latched_frame_value;
        logic [31:0] copy_word;
        logic [`SFE_CNT_W-1:0] copies_left;
        logic [`SFE_CNT_W-1:0] level;
        logic [`SFE_STOR_W-1:0] storage;
    } sfe_seq_state_type;

    sfe_seq_state_type state_reg;
    sfe_seq_state_type state_next;

    logic port_start;
    sfe_pkg::sfe_mem_type port_op;
    logic port_done;
    logic [31:0] port_rdata;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one doubleword step down the stack
    function automatic logic [`SFE_ADDR_W-1:0] word_down(input logic [`SFE_ADDR_W-1:0] a);
        word_down = a - `SFE_WORD_BYTES;
    endfunction : word_down

    // one doubleword step up the stack
    function automatic logic [`SFE_ADDR_W-1:0] word_up(input logic [`SFE_ADDR_W-1:0] a);
        word_up = a + `SFE_WORD_BYTES;
    endfunction : word_up

    // build a memory access
    function automatic sfe_pkg::sfe_mem_type mem_access(
        input logic we,
        input logic [`SFE_ADDR_W-1:0] a,
        input logic [31:0] d
    );
        mem_access.we = we;
        mem_access.addr = a;
        mem_access.wdata = d;
    endfunction : mem_access

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        port_start = 1'b0;
        port_op = mem_access(1'b0, state_reg.sp, 32'h0000_0000);
        // segment default follows the base register choice only
        state_next.stack_seg = agu_base_is_bp; // R9
        unique case (state_reg.fsm)
            ST_IDLE: begin
                state_next.ready = 1'b1;
                if (reg_wr_en) begin
                    // writes only land while idle so a sequence never sees them mid-way
                    if (reg_wr_sel_bp) begin
                        state_next.bp = reg_wr_data;
                    end else begin
                        state_next.sp = reg_wr_data;
                    end
                end
                if (cmd_valid && state_reg.ready) begin
                    state_next.ready = 1'b0;
                    state_next.issued = 1'b0;
                    state_next.storage = cmd.storage; // R1
                    // depth feeds only the copy count, never a privilege check
                    state_next.level = cmd.level[`SFE_LVL_MSB:0]; // R14 R10
                    if (cmd.op == sfe_pkg::SFE_OP_ENTER) begin
                        state_next.sp = word_down(state_reg.sp); // R13
                        state_next.fsm = ST_PUSH_BP;
                    end else begin
                        state_next.sp = state_reg.bp; // R11
                        state_next.fsm = ST_POP_BP;
                    end
                end
            end
            ST_PUSH_BP: begin
                if (!state_reg.issued) begin
                    port_start = 1'b1;
                    port_op = mem_access(1'b1, state_reg.sp, state_reg.bp); // R7 R2
                    state_next.issued = 1'b1;
                end else if (port_done) begin
                    state_next.issued = 1'b0;
                    state_next.latched_frame_value = state_reg.sp; // R3
                    state_next.copies_left = state_reg.level - 5'h01; // R3
                    if (state_reg.level == 5'h00) begin
                        state_next.fsm = ST_FINISH; // R2
                    end else if (state_reg.level == 5'h01) begin
                        state_next.sp = word_down(state_reg.sp); // R8
                        state_next.fsm = ST_PUSH_FRAME;
                    end else begin
                        state_next.bp = word_down(state_reg.bp); // R3
                        state_next.fsm = ST_COPY_RD;
                    end
                end
            end
            ST_COPY_RD: begin
                if (!state_reg.issued) begin
                    port_start = 1'b1;
                    port_op = mem_access(1'b0, state_reg.bp, 32'h0000_0000); // R3
                    state_next.issued = 1'b1;
                end else if (port_done) begin
                    state_next.issued = 1'b0;
                    state_next.copy_word = port_rdata;
                    state_next.sp = word_down(state_reg.sp); // R13
                    state_next.fsm = ST_COPY_WR;
                end
            end
            ST_COPY_WR: begin
                if (!state_reg.issued) begin
                    port_start = 1'b1;
                    port_op = mem_access(1'b1, state_reg.sp, state_reg.copy_word); // R7
                    state_next.issued = 1'b1;
                end else if (port_done) begin
                    state_next.issued = 1'b0;
                    state_next.copies_left = state_reg.copies_left - 5'h01;
                    if (state_reg.copies_left == 5'h01) begin
                        state_next.sp = word_down(state_reg.sp); // R13
                        state_next.fsm = ST_PUSH_FRAME;
                    end else begin
                        state_next.bp = word_down(state_reg.bp); // R3
                        state_next.fsm = ST_COPY_RD;
                    end
                end
            end
            ST_PUSH_FRAME: begin
                if (!state_reg.issued) begin
                    port_start = 1'b1;
                    port_op = mem_access(1'b1, state_reg.sp, state_reg.latched_frame_value); // R4 R8
                    state_next.issued = 1'b1;
                end else if (port_done) begin
                    state_next.issued = 1'b0;
                    state_next.fsm = ST_FINISH;
                end
            end
            ST_FINISH: begin
                // base now names the highest display word
                state_next.bp = state_reg.latched_frame_value; // R5 R6
                state_next.sp = state_reg.sp - {{(`SFE_ADDR_W-`SFE_STOR_W){1'b0}}, state_reg.storage}; // R5
                state_next.done = 1'b1;
                state_next.ready = 1'b1;
                state_next.fsm = ST_IDLE;
            end
            ST_POP_BP: begin
                if (!state_reg.issued) begin
                    port_start = 1'b1;
                    port_op = mem_access(1'b0, state_reg.sp, 32'h0000_0000); // R12
                    state_next.issued = 1'b1;
                end else if (port_done) begin
                    state_next.issued = 1'b0;
                    state_next.bp = port_rdata; // R12
                    state_next.sp = word_up(state_reg.sp); // R13
                    state_next.done = 1'b1;
                    state_next.ready = 1'b1;
                    state_next.fsm = ST_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register, frozen while the clock enable is low
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.fsm <= ST_IDLE;
            state_reg.sp <= `SFE_SP_RESET;
            state_reg.bp <= `SFE_BP_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // stack memory access, one at a time
    sfe_stack_port u_port (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .start(port_start),
        .op(port_op),
        .done(port_done),
        .rdata(port_rdata),
        .mem_req(mem_req),
        .mem_op(mem_op),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );

    // outputs straight from the state register
    assign cmd_ready = state_reg.ready;
    assign cmd_done = state_reg.done;
    assign frame_base_pointer = state_reg.bp;
    assign stack_pointer_reg = state_reg.sp;
    assign agu_use_stack_seg = state_reg.stack_seg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_enter_push_base: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_IDLE && state_reg.ready && cmd_valid && cmd.op == sfe_pkg::SFE_OP_ENTER)
        |=> (state_reg.sp == $past(state_reg.sp) - `SFE_WORD_BYTES)) // R13
        else $error("enter did not predecrement stack by four");

    a_first_push_base: assert property (@(posedge core_clk) disable iff (!rst_n)
        (port_start && state_reg.fsm == ST_PUSH_BP) |-> (port_op.we && port_op.wdata == state_reg.bp)) // R7
        else $error("first push is not the old base");

    a_leave_copy_sp: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_IDLE && state_reg.ready && cmd_valid && cmd.op == sfe_pkg::SFE_OP_LEAVE)
        |=> (state_reg.sp == $past(state_reg.bp) && state_reg.fsm == ST_POP_BP)) // R11
        else $error("leave did not copy base into stack pointer");

    a_leave_pop_done: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_POP_BP && port_done)
        |=> (state_reg.bp == $past(port_rdata) && state_reg.sp == $past(state_reg.sp) + `SFE_WORD_BYTES)) // R12
        else $error("leave pop result wrong");

    a_finish_alloc: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_FINISH)
        |=> (state_reg.bp == $past(state_reg.latched_frame_value) && cmd_done
             && state_reg.sp == $past(state_reg.sp) - {16'h0000, $past(state_reg.storage)})) // R5
        else $error("finish did not set base and allocate storage");

    a_level_zero_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_PUSH_BP && state_reg.issued && port_done && state_reg.level == 5'h00)
        |=> (state_reg.fsm == ST_FINISH)) // R2
        else $error("depth zero did not skip the display");

    a_frame_push_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        (port_start && state_reg.fsm == ST_PUSH_FRAME)
        |-> (port_op.we && port_op.wdata == state_reg.latched_frame_value)) // R4
        else $error("final display entry is not the latched frame value");

    a_copy_step_down: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_COPY_WR && port_done && state_reg.copies_left != 5'h01)
        |=> (state_reg.bp == $past(state_reg.bp) - `SFE_WORD_BYTES && state_reg.fsm == ST_COPY_RD)) // R3
        else $error("copy loop did not lower base by four");

    a_level_low_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && state_reg.fsm == ST_IDLE && state_reg.ready && cmd_valid)
        |=> (state_reg.level == $past(cmd.level[4:0]))) // R14
        else $error("depth not reduced to five bits");

    a_stack_segment: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en |=> (agu_use_stack_seg == $past(agu_base_is_bp))) // R9
        else $error("base-relative access not steered to stack segment");

endmodule : sfe_frame_seq

// >>> logic/sfe_pkg.sv
// types shared by the frame sequencer and its stack access port
// assumes sfe_defines.svh is on the include path
`include "sfe_defines.svh"

package sfe_pkg;

    // ----------------------------------------------------------------
    // command carried from the instruction decoder
    // ----------------------------------------------------------------
    typedef enum logic {
        SFE_OP_ENTER,
        SFE_OP_LEAVE
    } sfe_op_type;

    typedef struct packed {
        sfe_op_type op;
        logic [`SFE_STOR_W-1:0] storage;
        logic [`SFE_LVL_IN_W-1:0] level;
    } sfe_cmd_type;

    // ----------------------------------------------------------------
    // one doubleword access toward stack memory
    // ----------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [`SFE_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } sfe_mem_type;

endpackage : sfe_pkg

// >>> logic/sfe_stack_port.sv
// single outstanding doubleword access toward stack memory
// assumes memory answers with a one-cycle ack on core_clk, any later cycle
`timescale 1ns/1ps

module sfe_stack_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // request from the sequencer
    input wire logic start,
    input sfe_pkg::sfe_mem_type op,
    output logic done,
    output logic [31:0] rdata,
    // memory side
    output logic mem_req,
    output sfe_pkg::sfe_mem_type mem_op,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);

    typedef struct packed {
        logic req;
        sfe_pkg::sfe_mem_type op;
        logic done;
        logic [31:0] rdata;
    } sfe_port_state_type;

    sfe_port_state_type state_reg;
    sfe_port_state_type state_next;

    // ----------------------------------------------------------------
    // request held until the ack; a start while busy is ignored
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        if (state_reg.req) begin
            if (mem_ack) begin
                state_next.req = 1'b0;
                state_next.done = 1'b1;
                state_next.rdata = state_reg.op.we ? state_reg.rdata : mem_rdata;
            end
        end else if (start) begin
            state_next.req = 1'b1;
            state_next.op = op;
        end
    end

    // state frozen while the clock enable is low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
    assign rdata = state_reg.rdata;
    assign mem_req = state_reg.req;
    assign mem_op = state_reg.op;

endmodule : sfe_stack_port

// >>> tb/sfe_frame_seq_test.sv
// self-checking bench for the frame creation and release sequencer
// assumes the stack memory model of sfe_stack_mem.sv and a 100 MHz core_clk
`timescale 1ns/1ps

module sfe_frame_seq_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic cmd_valid = 1'b0;
    sfe_pkg::sfe_cmd_type cmd = '0;
    logic cmd_ready;
    logic cmd_done;
    logic reg_wr_en = 1'b0;
    logic reg_wr_sel_bp = 1'b0;
    logic [31:0] reg_wr_data = 32'h0000_0000;
    logic [31:0] frame_base_pointer;
    logic [31:0] stack_pointer_reg;
    logic agu_base_is_bp = 1'b0;
    logic agu_use_stack_seg;
    logic mem_req;
    logic mem_ack;
    sfe_pkg::sfe_mem_type mem_op;
    logic [31:0] mem_rdata;
    logic en_rand = 1'b0;
    logic prev_agu = 1'b0;
    logic prev_en = 1'b0;
    logic [31:0] ex_sp = 32'h0000_0000;
    logic [31:0] ex_bp = 32'h0000_0000;
    logic [31:0] ex_mem [logic [31:0]];
    logic [7:0] lv_tab [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h1f, 8'he3, 8'h20};
    logic [15:0] st_tab [7] = '{16'h0000, 16'hffff, 16'h0800, 16'h000c, 16'h0004, 16'h0010, 16'h0001};
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int depth = 0;

    // ----------------------------------------------------------------
    // design and far side
    // ----------------------------------------------------------------
    sfe_frame_seq dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .reg_wr_en(reg_wr_en),
        .reg_wr_sel_bp(reg_wr_sel_bp), .reg_wr_data(reg_wr_data), .frame_base_pointer(frame_base_pointer),
        .stack_pointer_reg(stack_pointer_reg), .agu_base_is_bp(agu_base_is_bp),
        .agu_use_stack_seg(agu_use_stack_seg), .mem_req(mem_req), .mem_op(mem_op), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    sfe_stack_mem mem_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .mem_req(mem_req),
        .mem_op(mem_op), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ----------------------------------------------------------------
    // clock, free-running inputs, monitors
    // ----------------------------------------------------------------
    // free-running clock
    always #5 core_clk = ~core_clk;

    // clk_en drops one cycle in eight while en_rand is set, to prove the freeze
    always @(posedge core_clk) begin
        #1;
        agu_base_is_bp = 1'($urandom);
        clk_en = en_rand ? ($urandom_range(7, 0) != 0) : 1'b1;
    end

    // remember what the design saw at each edge
    always @(posedge core_clk) begin
        prev_agu <= agu_base_is_bp;
        prev_en <= clk_en && rst_n;
    end

    // segment default follows the base flag one enabled edge later; hang guard
    always @(negedge core_clk) begin
        cycles++;
        if (rst_n && prev_en) check(agu_use_stack_seg, prev_agu, "segment default");
        if (cycles > 40000) begin
            err_total++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // comparison and expectation
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    function automatic logic [31:0] ex_rd(input logic [31:0] a);
        return ex_mem.exists(a) ? ex_mem[a] : mem_u.fill(a);
    endfunction : ex_rd

    // pushes lower the pointer first, then store
    task automatic ex_push(input logic [31:0] v);
        ex_sp = ex_sp - 32'h0000_0004;
        ex_mem[ex_sp] = v;
    endtask : ex_push

    // frame creation as the bench expects it; only five level bits count
    task automatic ex_enter(input logic [15:0] s, input logic [7:0] l);
        logic [31:0] fr;
        ex_push(ex_bp);
        fr = ex_sp;
        if (l[4:0] != 5'h00) begin
            for (int i = 1; i < int'(l[4:0]); i++) begin
                ex_bp = ex_bp - 32'h0000_0004;
                ex_push(ex_rd(ex_bp));
            end
            ex_push(fr);
        end
        ex_bp = fr;
        ex_sp = ex_sp - {16'h0000, s};
    endtask : ex_enter

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task automatic reg_write(input logic sel, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        reg_wr_en = 1'b1;
        reg_wr_sel_bp = sel;
        reg_wr_data = d;
        @(negedge core_clk);
        while (clk_en !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        #1 reg_wr_en = 1'b0;
        @(negedge core_clk);
        check(sel ? frame_base_pointer : stack_pointer_reg, d, "pointer write");
        if (sel) ex_bp = d;
        else ex_sp = d;
    endtask : reg_write

    // one command; chain keeps valid up with a release queued, to be taken on the done cycle
    task automatic do_cmd(input logic op, input logic [15:0] s, input logic [7:0] l, input logic chain);
        if (!cmd_valid) begin
            @(posedge core_clk);
            #1;
            cmd.op = sfe_pkg::sfe_op_type'(op);
            cmd.storage = s;
            cmd.level = l;
            cmd_valid = 1'b1;
            @(negedge core_clk);
        end
        while (!(cmd_ready === 1'b1 && clk_en === 1'b1)) @(negedge core_clk);
        @(posedge core_clk);
        #1;
        if (chain) cmd.op = sfe_pkg::SFE_OP_LEAVE;
        else cmd_valid = 1'b0;
        reg_wr_en = 1'b1; // writes while busy must be ignored
        reg_wr_sel_bp = 1'($urandom);
        reg_wr_data = $urandom;
        repeat (2) @(posedge core_clk);
        #1 reg_wr_en = 1'b0;
        while (cmd_done !== 1'b1) @(negedge core_clk);
        if (op) begin
            ex_sp = ex_bp;
            ex_bp = ex_rd(ex_sp);
            ex_sp = ex_sp + 32'h0000_0004;
        end else begin
            ex_enter(s, l);
        end
        check(frame_base_pointer, ex_bp, "frame base");
        check(stack_pointer_reg, ex_sp, "stack pointer");
        check(mem_u.mem.num(), ex_mem.num(), "words written");
        foreach (ex_mem[a]) check(mem_u.mem[a], ex_mem[a], "stack word");
        // a queued release is taken at the next enabled edge, so the next call starts on the done cycle
        if (!chain) @(negedge core_clk);
    endtask : do_cmd

    task automatic final_report();
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(81511));
        repeat (8) @(posedge core_clk);
        check(stack_pointer_reg, 32'h0000_0000, "reset stack");
        check(frame_base_pointer, 32'h0000_0000, "reset base");
        check(cmd_ready, 1'b0, "reset ready");
        #1 rst_n = 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        check(cmd_ready, 1'b1, "ready after reset");
        reg_write(1'b0, 32'h0004_0000 + ($urandom & 32'h0000_fffc));
        reg_write(1'b1, ex_sp + 32'h0000_0040);
        en_rand = 1'b1;
        // corner levels and counts, odd entries chained back to back into their release
        foreach (lv_tab[i]) begin
            do_cmd(1'b0, st_tab[i], lv_tab[i], i[0]);
            do_cmd(1'b1, 16'h0000, 8'h00, 1'b0);
        end
        // random nesting, so copies read real earlier displays
        repeat (14) begin
            do_cmd(1'b0, 16'($urandom_range(64, 0)), 8'($urandom), 1'b0);
            depth++;
            if (depth > 0 && $urandom_range(2, 0) == 0) begin
                do_cmd(1'b1, 16'h0000, 8'h00, 1'b0);
                depth--;
            end
        end
        // reset in the middle of a deep creation
        en_rand = 1'b0;
        @(posedge core_clk);
        #1;
        cmd.op = sfe_pkg::SFE_OP_ENTER;
        cmd.level = 8'h1f;
        cmd_valid = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        @(negedge core_clk);
        check(stack_pointer_reg, 32'h0000_0000, "mid reset stack");
        check(frame_base_pointer, 32'h0000_0000, "mid reset base");
        check(mem_req, 1'b0, "mid reset request");
        @(posedge core_clk);
        #1 rst_n = 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        check(cmd_ready, 1'b1, "ready after second reset");
        final_report();
    end
endmodule : sfe_frame_seq_test

// >>> tb/sfe_stack_mem.sv
// behavioural stack memory answering the doubleword requests of the frame sequencer
// assumes one outstanding request and the same core_clk and clk_en as the sequencer
`timescale 1ns/1ps

module sfe_stack_mem (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // request side
    input wire logic mem_req,
    input sfe_pkg::sfe_mem_type mem_op,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    int wait_cnt;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // unwritten words carry an address pattern, so a copy from the wrong place shows
    function automatic logic [31:0] fill(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction : fill

    // answer after 0..3 idle cycles; only enabled edges count, so ack stands until seen
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            wait_cnt <= 0;
        end else if (clk_en) begin
            if (mem_ack || !mem_req) begin
                mem_ack <= 1'b0;
                mem_rdata <= ~mem_rdata; // released data never looks valid
            end else if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end else begin
                mem_ack <= 1'b1;
                wait_cnt <= $urandom_range(3, 0);
                if (mem_op.we) begin
                    mem[mem_op.addr] = mem_op.wdata;
                end
                mem_rdata <= mem.exists(mem_op.addr) ? mem[mem_op.addr] : fill(mem_op.addr);
            end
        end
    end
endmodule : sfe_stack_mem
